// ---- rtl/asrc_sync_reset.sv ----
// Summary of operation
// - Sync bit set holds filter, modulator reset
// - Sync cleared: sampling resumes second clock after write
// - Sync touches only filter and modulator state
// - Three output periods settle before loading
// - Sync release never forces data-ready high
// - Update while low pulses high 500 clocks
// - Read sets high; stays until next word loads
// - High at sync with no unread word stays high until settled
// - Sync write acts as single-shot start
// - Reset input low resets all logic
// - Reset holds data-ready high, ignores access
// - After reset, word ready three periods later
// - Clock output runs through reset
// - Master clock driven to clock output
// - All rates scale with master clock
// - Modulator cycle is 128 master clocks
`timescale 1ns/100ps
`include "asrc_defines.svh"
module asrc_sync_reset
  import asrc_pkg::*;
#(
  parameter int MOD_CYCLE = `ASRC_MOD_CYCLE,
  parameter int UPDATE_PULSE = `ASRC_UPDATE_PULSE,
  parameter int SETTLE_PERIODS = `ASRC_SETTLE_PERIODS,
  parameter int DATA_W = 16
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial-port derived setup writes
  input wire logic sync_wr,
  input wire logic sync_wr_value,
  input wire logic [15:0] rate_div_wr_value,
  input wire logic rate_div_wr,
  // Data register read strobe from serial port
  input wire logic data_rd,
  // Filter result stream
  input wire logic [DATA_W-1:0] filter_word,
  output logic clk_out,
  output logic filter_sync_hold,
  output logic filter_reset,
  output logic [15:0] rate_div,
  output logic [DATA_W-1:0] data_word,
  output logic data_ready_n
);
  localparam logic [9:0] PULSE_LAST = 10'(UPDATE_PULSE - 1);
  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_PERIODS - 1);
  typedef struct packed
  {
    logic hold;
    logic [15:0] div;
    asrc_state_t state;
    logic [1:0] settle_cnt;
    logic [DATA_W-1:0] word;
    logic unread;
    logic pulse;
    logic [9:0] pulse_cnt;
  } asrc_ctl_t;
  asrc_ctl_t st;
  asrc_ctl_t next_st;
  logic rate_tick;
  logic run;
  assign run = (st.state != ASRC_HOLD);
  // One timer drives both settling and steady updates, so rates follow the clock
  asrc_rate_timer #(
    .MOD_CYCLE(MOD_CYCLE)
  ) u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(run),
    .rate_div(st.div),
    .rate_tick(rate_tick)
  );
  always_comb
  begin
    next_st = st;
    // Each setup write changes only its own field; other setup is left alone
    if (rate_div_wr)
    begin
      next_st.div = (rate_div_wr_value == 16'h0000) ? 16'h0001 : rate_div_wr_value;
    end
    if (sync_wr)
    begin
      next_st.hold = sync_wr_value;
    end
    if (data_rd)
    begin
      next_st.unread = 1'b0;
      next_st.pulse = 1'b0;
    end
    if (st.pulse)
    begin
      if (st.pulse_cnt == PULSE_LAST)
      begin
        next_st.pulse = 1'b0;
        next_st.pulse_cnt = 10'h000;
      end
      else
      begin
        next_st.pulse_cnt = st.pulse_cnt + 10'h001;
      end
    end
    unique case (st.state)
      ASRC_HOLD:
      begin
        next_st.settle_cnt = 2'b00;
        if (!st.hold)
        begin
          next_st.state = ASRC_SETTLE;
        end
      end
      ASRC_SETTLE:
      begin
        // Unread word is kept, so data-ready is not forced high here
        if (rate_tick)
        begin
          if (st.settle_cnt == SETTLE_LAST)
          begin
            next_st.state = ASRC_RUN;
            next_st.word = filter_word;
            next_st.pulse = st.unread && !data_rd;
            next_st.pulse_cnt = 10'h000;
            next_st.unread = 1'b1;
          end
          else
          begin
            next_st.settle_cnt = st.settle_cnt + 2'b01;
          end
        end
      end
      ASRC_RUN:
      begin
        if (rate_tick)
        begin
          next_st.word = filter_word;
          next_st.pulse = st.unread && !data_rd;
          next_st.pulse_cnt = 10'h000;
          next_st.unread = 1'b1;
        end
      end
      default:
      begin
        next_st.state = ASRC_HOLD;
      end
    endcase
    // A fresh sync write restarts settling; single-shot start uses this path
    if (sync_wr)
    begin
      next_st.state = ASRC_HOLD;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      // Serial inputs are ignored while reset is low
      st.hold <= `ASRC_SYNC_HOLD_RESET;
      st.div <= `ASRC_RATE_DIV_DEFAULT;
      st.state <= ASRC_HOLD;
      st.settle_cnt <= 2'b00;
      st.word <= '0;
      st.unread <= 1'b0;
      st.pulse <= 1'b0;
      st.pulse_cnt <= 10'h000;
    end
    else
    begin
      st <= next_st;
    end
  end
  // Clock passes straight out, independent of reset
  assign clk_out = ref_clk;
  assign filter_sync_hold = st.hold;
  assign filter_reset = !run;
  assign rate_div = st.div;
  assign data_word = st.word;
  assign data_ready_n = !(st.unread && !st.pulse);
endmodule : asrc_sync_reset

// ---- rtl/asrc_defines.svh ----
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
// Master clock period in ns (125 MHz)
`define ASRC_CLK_PERIOD_NS 8
// Modulator cycle in master clocks
`define ASRC_MOD_CYCLE 128
// Data-ready high pulse on update, in master clocks
`define ASRC_UPDATE_PULSE 500
// Settling in output-rate periods
`define ASRC_SETTLE_PERIODS 3
// Default output-rate period in modulator cycles
`define ASRC_RATE_DIV_DEFAULT 16'h0040
`define ASRC_SYNC_HOLD_RESET 1'b0
`endif

// ---- rtl/asrc_pkg.sv ----
package asrc_pkg;
  typedef enum logic [1:0]
  {
    ASRC_HOLD = 2'b00,
    ASRC_SETTLE = 2'b01,
    ASRC_RUN = 2'b10
  } asrc_state_t;
endpackage : asrc_pkg

// ---- rtl/asrc_rate_timer.sv ----
`timescale 1ns/100ps
`include "asrc_defines.svh"
// Produces one pulse per output-rate period while run is high; restarts when run is low
module asrc_rate_timer
  import asrc_pkg::*;
#(
  parameter int MOD_CYCLE = `ASRC_MOD_CYCLE
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [15:0] rate_div,
  output logic rate_tick
);
  typedef struct packed
  {
    logic [7:0] mclk_cnt;
    logic [15:0] mod_cnt;
    logic tick;
  } asrc_timer_t;
  asrc_timer_t st;
  asrc_timer_t next_st;
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run)
    begin
      next_st.mclk_cnt = 8'h00;
      next_st.mod_cnt = 16'h0000;
    end
    else if (st.mclk_cnt == 8'(MOD_CYCLE - 1))
    begin
      next_st.mclk_cnt = 8'h00;
      if (st.mod_cnt >= rate_div - 16'h0001)
      begin
        next_st.mod_cnt = 16'h0000;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.mod_cnt = st.mod_cnt + 16'h0001;
      end
    end
    else
    begin
      next_st.mclk_cnt = st.mclk_cnt + 8'h01;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign rate_tick = st.tick;
endmodule : asrc_rate_timer

// ---- sim/asrc_chk_sva.sv ----
`timescale 1ns/100ps
module asrc_chk(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sync_wr,
  input wire logic sync_wr_value,
  input wire logic rate_div_wr,
  input wire logic data_rd,
  input wire logic filter_sync_hold,
  input wire logic filter_reset,
  input wire logic [15:0] rate_div,
  input wire logic data_ready_n
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence rel_s;
    sync_wr && !sync_wr_value ##1 !sync_wr;
  endsequence
  sequence upd_s;
    !data_ready_n && !data_rd ##1 data_ready_n;
  endsequence
  a_rst_ready:
    assert property (disable iff (1'b0) !rstn |=> data_ready_n) else $error("ready low");
  a_hold_reset:
    assert property (filter_sync_hold |-> filter_reset) else $error("not held");
  a_sync_go:
    assert property (rel_s |=> !filter_reset) else $error("no release");
  a_keep_cfg:
    assert property (sync_wr && !rate_div_wr |=> $stable(rate_div)) else $error("cfg lost");
  a_settle_high:
    assert property (sync_wr && data_ready_n |=> data_ready_n[*5]) else $error("early");
  a_upd_pulse:
    assert property (upd_s |-> (data_ready_n || $past(data_rd))[*7]) else $error("short");
  a_read_high:
    assert property (data_rd |=> data_ready_n) else $error("read");
  a_boot_word:
    assert property ($rose(rstn) |-> data_ready_n[*5] ##[1:1000] !data_ready_n)
    else $error("no word");
endmodule : asrc_chk
bind asrc_sync_reset asrc_chk i_asrc_chk(.*);

// ---- sim/asrc_host.sv ----
`timescale 1ns/100ps
module asrc_host(
  input wire logic ref_clk,
  output logic sync_wr,
  output logic sync_wr_value,
  output logic rate_div_wr,
  output logic [15:0] rate_div_wr_value,
  output logic data_rd
);
  initial {sync_wr, sync_wr_value, rate_div_wr, rate_div_wr_value, data_rd} = '0;
  // Strobes are cleared and stale data values inverted so a held value is never trusted
  task put(input logic [3:0] k, input logic [15:0] w);
    @(negedge ref_clk);
    {sync_wr, sync_wr_value, rate_div_wr, data_rd} = k;
    rate_div_wr_value = w;
    @(negedge ref_clk);
    {sync_wr, sync_wr_value, rate_div_wr, data_rd} = {1'h0, ~k[2], 2'h0};
    rate_div_wr_value = ~w;
  endtask : put
endmodule : asrc_host

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic ref_clk, rstn, sync_wr, sync_wr_value, rate_div_wr, data_rd, clk_out;
  logic filter_sync_hold, filter_reset, data_ready_n;
  logic [15:0] rate_div_wr_value, rate_div, data_word;
  logic [15:0] filter_word = 16'h5A5A;
  int miscompares, checks_done, n;
  asrc_sync_reset #(.MOD_CYCLE(2), .UPDATE_PULSE(8)) i_asrc_sync_reset(.*);
  asrc_host i_asrc_host(.*);
  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  task chk(input logic [17:0] got, exp);
    checks_done++;
    miscompares += int'(got !== exp);
    if (got !== exp)
      $display("wrong value at %0t: %h", $time, got);
  endtask : chk
  task wt(input logic v, input logic [17:0] exp);
    for (n = 0; data_ready_n !== v && n < 999; n++) @(negedge ref_clk);
    chk(18'(n / 8), exp);
  endtask : wt
  task test_done;
    $display("%0d wrong of %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task t_reset;
    chk(18'({data_ready_n, rate_div}), 18'h10040);
    chk(18'(clk_out), 18'(ref_clk));
    i_asrc_host.put(4'hC, 16'h0000);
    rstn = 1'h1;
    wt(1'h0, 18'h30);
    chk(18'(filter_sync_hold), 18'h00000);
    chk(18'(data_word), 18'h05A5A);
  endtask : t_reset
  task t_sync;
    i_asrc_host.put(4'h2, 16'h0010);
    i_asrc_host.put(4'hC, 16'h0000);
    @(negedge ref_clk);
    chk(18'({filter_sync_hold, filter_reset, rate_div}), 18'h30010);
    i_asrc_host.put(4'h8, 16'h0000);
    chk(18'(data_ready_n), 18'h00000);
    wt(1'h1, 18'hC);
    wt(1'h0, 18'h1);
    i_asrc_host.put(4'h1, 16'h0000);
    chk(18'(data_ready_n), 18'h00001);
    i_asrc_host.put(4'h8, 16'h0000);
    wt(1'h0, 18'hC);
  endtask : t_sync
  initial
  begin
    {rstn, miscompares, checks_done} = '0;
    repeat (4) @(negedge ref_clk);
    t_reset;
    t_sync;
    test_done;
  end
  initial
  begin
    #20000;
    miscompares++;
    test_done;
  end
endmodule : testbench
